// [core/l2bw_pkg.sv]
// Package for the L2 bandwidth arbiter: register map, fields, reset values, requesters
package l2bw_pkg;
  // Register byte addresses
  localparam logic [31:0] L2BW_ADDR_DMA_CNT = 32'h0182_0110;
  localparam logic [31:0] L2BW_ADDR_CPU_ARB = 32'h0184_1000;
  localparam logic [31:0] L2BW_ADDR_MST_A = 32'h01c1_4114;
  localparam logic [31:0] L2BW_ADDR_MST_B = 32'h01c1_4118;
  localparam logic [31:0] L2BW_ADDR_MAX_WAIT = 32'h0184_1004;
  localparam logic [31:0] L2BW_ADDR_STATUS = 32'h0184_1008;
  // Field layout
  localparam int L2BW_PRI_W = 3;
  localparam int L2BW_CPU_PRI_LSB = 16;
  localparam int L2BW_DMA_PRI_LSB = 29;
  localparam int L2BW_MST_NUM = 8;
  localparam int L2BW_MST_LSB_STEP = 4;
  localparam int L2BW_MST_ID_W = 3;
  localparam int L2BW_CNT_W = 8;
  // Reset values
  localparam logic [31:0] L2BW_RST_CPU_ARB = 32'h0001_0000;
  localparam logic [31:0] L2BW_RST_DMA_CNT = 32'h0000_0000;
  localparam logic [31:0] L2BW_RST_MST = 32'h4444_4444;
  localparam logic [7:0] L2BW_RST_MAX_WAIT = 8'h10;
  // Requesters
  typedef enum logic [1:0] {
    L2BW_NONE = 2'b00,
    L2BW_CPU = 2'b01,
    L2BW_LDMA = 2'b11,
    L2BW_PDMA = 2'b10
  } l2bw_req_t;
endpackage : l2bw_pkg

// [core/l2bw_arbiter.sv]
// L2 RAM bandwidth arbiter between CPU, internal DMA and slave-port DMA
// What this block does
// - Arbitrate L2 by priority and contention counters
// - Internal and slave-port requests count as DMA
// - Blocked pending requester counts contention cycles
// - Counter at threshold forces a bandwidth grant
// - Equal CPU and DMA priorities share fairly
// - CPU priority from CPU arbitration register
// - Internal DMA priority from count register field
// - Slave DMA priority from master priority field
`timescale 1ns/100ps
module l2bw_arbiter
  import l2bw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Requesters
  input wire logic cpu_req,
  input wire logic ldma_req,
  input wire logic pdma_req,
  input wire logic [l2bw_pkg::L2BW_MST_ID_W-1:0] pdma_master_id,
  // Grants, one-hot, one cycle each
  output logic cpu_gnt,
  output logic ldma_gnt,
  output logic pdma_gnt
);
  import l2bw_pkg::*;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [31:0] cpu_arb_reg;
  logic [31:0] dma_cnt_reg;
  logic [31:0] mst_a_reg;
  logic [31:0] mst_b_reg;
  logic [L2BW_CNT_W-1:0] max_wait_reg;
  logic last_dma_reg;
  logic [L2BW_CNT_W-1:0] cnt_reg [3];
  l2bw_req_t last_gnt_reg;

  // Unmapped writes fall through and are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpu_arb_reg <= L2BW_RST_CPU_ARB;
      dma_cnt_reg <= L2BW_RST_DMA_CNT;
      mst_a_reg <= L2BW_RST_MST;
      mst_b_reg <= L2BW_RST_MST;
      max_wait_reg <= L2BW_RST_MAX_WAIT;
    end else if (reg_wr) begin
      unique case (reg_addr)
        L2BW_ADDR_CPU_ARB: cpu_arb_reg <= reg_wdata;
        L2BW_ADDR_DMA_CNT: dma_cnt_reg <= reg_wdata;
        L2BW_ADDR_MST_A: mst_a_reg <= reg_wdata;
        L2BW_ADDR_MST_B: mst_b_reg <= reg_wdata;
        L2BW_ADDR_MAX_WAIT: max_wait_reg <= reg_wdata[L2BW_CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Priority extraction
  // ------------------------------------------------------------------
  // Masters 0-3 sit in word A, 4-7 in word B, one nibble each
  function automatic logic [L2BW_PRI_W-1:0] mst_pri(
      input logic [L2BW_MST_ID_W-1:0] id,
      input logic [31:0] a,
      input logic [31:0] b);
    logic [31:0] word;
    int lsb;
    word = id[L2BW_MST_ID_W-1] ? b : a;
    lsb = (int'(id) * L2BW_MST_LSB_STEP) % $bits(word);
    mst_pri = word[lsb +: L2BW_PRI_W];
  endfunction : mst_pri

  logic [L2BW_PRI_W-1:0] pri_cpu;
  logic [L2BW_PRI_W-1:0] pri_ldma;
  logic [L2BW_PRI_W-1:0] pri_pdma;
  assign pri_cpu = cpu_arb_reg[L2BW_CPU_PRI_LSB +: L2BW_PRI_W];
  assign pri_ldma = dma_cnt_reg[L2BW_DMA_PRI_LSB +: L2BW_PRI_W];
  assign pri_pdma = mst_pri(pdma_master_id, mst_a_reg, mst_b_reg);

  // ------------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------------
  // Both DMA sources form one DMA class; best DMA picked first
  function automatic l2bw_req_t dma_pick(input logic is_ldma);
    dma_pick = is_ldma ? L2BW_LDMA : L2BW_PDMA;
  endfunction : dma_pick

  logic dma_req;
  logic dma_is_ldma;
  logic [L2BW_PRI_W-1:0] pri_dma;
  always_comb begin
    dma_req = ldma_req | pdma_req;
    dma_is_ldma = ldma_req &&
                  (!pdma_req || pri_ldma < pri_pdma ||
                   (pri_ldma == pri_pdma && last_gnt_reg != L2BW_LDMA));
    pri_dma = dma_is_ldma ? pri_ldma : pri_pdma;
  end

  logic [2:0] req_vec;
  logic [2:0] starved;
  assign req_vec = {pdma_req, ldma_req, cpu_req};
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      starved[i] = req_vec[i] && cnt_reg[i] >= max_wait_reg;
    end
  end

  l2bw_req_t winner;
  always_comb begin
    winner = L2BW_NONE;
    if (|starved) begin
      // Starved request takes a slice ahead of priority
      if (starved[0]) winner = L2BW_CPU;
      else if (starved[1]) winner = L2BW_LDMA;
      else winner = L2BW_PDMA;
    end else if (cpu_req && dma_req) begin
      // Lower value wins; a tie alternates so DMA is never starved
      if (pri_cpu < pri_dma) winner = L2BW_CPU;
      else if (pri_dma < pri_cpu) winner = dma_pick(dma_is_ldma);
      else if (last_dma_reg) winner = L2BW_CPU;
      else winner = dma_pick(dma_is_ldma);
    end else if (cpu_req) begin
      winner = L2BW_CPU;
    end else if (dma_req) begin
      winner = dma_pick(dma_is_ldma);
    end
  end

  logic [2:0] gnt_vec;
  assign gnt_vec = {winner == L2BW_PDMA, winner == L2BW_LDMA, winner == L2BW_CPU};
  assign cpu_gnt = gnt_vec[0];
  assign ldma_gnt = gnt_vec[1];
  assign pdma_gnt = gnt_vec[2];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      last_dma_reg <= 1'b0;
      last_gnt_reg <= L2BW_NONE;
    end else if (winner != L2BW_NONE) begin
      last_dma_reg <= winner != L2BW_CPU;
      last_gnt_reg <= winner;
    end
  end

  // ------------------------------------------------------------------
  // Contention counters
  // ------------------------------------------------------------------
  // Saturating, so a long stall cannot wrap back below threshold
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst || !req_vec[i] || gnt_vec[i]) begin
        cnt_reg[i] <= '0;
      end else if (cnt_reg[i] != '1) begin
        cnt_reg[i] <= cnt_reg[i] + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        L2BW_ADDR_CPU_ARB: reg_rdata <= cpu_arb_reg;
        L2BW_ADDR_DMA_CNT: reg_rdata <= dma_cnt_reg;
        L2BW_ADDR_MST_A: reg_rdata <= mst_a_reg;
        L2BW_ADDR_MST_B: reg_rdata <= mst_b_reg;
        L2BW_ADDR_MAX_WAIT: reg_rdata <= 32'(max_wait_reg);
        L2BW_ADDR_STATUS: reg_rdata <= {8'h00, cnt_reg[2], cnt_reg[1], cnt_reg[0]};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ------------------------------------------------------------------
  // Checks: grants
  // ------------------------------------------------------------------
  gnt_onehot_a: assert property (@(posedge sys_clk) disable iff (rst)
    $onehot0(gnt_vec))
    else $error("more than one grant");

  gnt_needs_req_a: assert property (@(posedge sys_clk) disable iff (rst)
    (gnt_vec & ~req_vec) == 3'b000)
    else $error("grant without request");

  idle_no_gnt_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_vec == 3'b000 |-> gnt_vec == 3'b000)
    else $error("grant while idle");

  busy_some_gnt_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_vec != 3'b000 |-> gnt_vec != 3'b000)
    else $error("requests left without grant");

  cpu_alone_a: assert property (@(posedge sys_clk) disable iff (rst)
    cpu_req && !dma_req |-> cpu_gnt)
    else $error("lone cpu request not granted");

  dma_class_a: assert property (@(posedge sys_clk) disable iff (rst)
    dma_req && !cpu_req |-> ldma_gnt || pdma_gnt)
    else $error("lone dma request not granted");

  // ------------------------------------------------------------------
  // Checks: priority
  // ------------------------------------------------------------------
  low_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
    cpu_req && ldma_req && !pdma_req && !(|starved) && pri_cpu < pri_ldma
    |-> cpu_gnt)
    else $error("lower value lost");

  dma_low_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
    cpu_req && dma_req && !(|starved) && pri_dma < pri_cpu
    |-> !cpu_gnt)
    else $error("higher cpu value won");

  tie_share_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cpu_gnt && ldma_req && !pdma_req && pri_ldma == pri_cpu && !(|starved))
      ##1 (cpu_req && ldma_req && !pdma_req && pri_ldma == pri_cpu && !(|starved))
      |-> ldma_gnt)
    else $error("tie not shared");

  tie_share_pdma_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cpu_gnt && pdma_req && !ldma_req && pri_pdma == pri_cpu && !(|starved))
      ##1 (cpu_req && pdma_req && !ldma_req && pri_pdma == pri_cpu && !(|starved))
      |-> pdma_gnt)
    else $error("tie not shared with port dma");

  // ------------------------------------------------------------------
  // Checks: starvation
  // ------------------------------------------------------------------
  starve_gnt_a: assert property (@(posedge sys_clk) disable iff (rst)
    starved[2] && !starved[0] && !starved[1] |-> pdma_gnt)
    else $error("starved not granted");

  starve_cpu_a: assert property (@(posedge sys_clk) disable iff (rst)
    starved[0] |-> cpu_gnt)
    else $error("starved cpu not granted");

  starve_ldma_a: assert property (@(posedge sys_clk) disable iff (rst)
    starved[1] && !starved[0] |-> ldma_gnt)
    else $error("starved internal dma not granted");

  // ------------------------------------------------------------------
  // Checks: counters
  // ------------------------------------------------------------------
  cnt_grows_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_vec[0] && !gnt_vec[0] && cnt_reg[0] != '1
    |=> cnt_reg[0] == $past(cnt_reg[0]) + 1'b1)
    else $error("cpu counter did not count");

  cnt_grows_ldma_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_vec[1] && !gnt_vec[1] && cnt_reg[1] != '1
    |=> cnt_reg[1] == $past(cnt_reg[1]) + 1'b1)
    else $error("internal dma counter did not count");

  cnt_grows_pdma_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_vec[2] && !gnt_vec[2] && cnt_reg[2] != '1
    |=> cnt_reg[2] == $past(cnt_reg[2]) + 1'b1)
    else $error("port dma counter did not count");

  cnt_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_vec[2] && !gnt_vec[2] && cnt_reg[2] == '1
    |=> cnt_reg[2] == '1)
    else $error("counter wrapped");

  cnt_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    gnt_vec[1] || !ldma_req |=> cnt_reg[1] == '0)
    else $error("counter not cleared");

  cnt_clear_cpu_a: assert property (@(posedge sys_clk) disable iff (rst)
    gnt_vec[0] || !cpu_req |=> cnt_reg[0] == '0)
    else $error("cpu counter not cleared");

  cnt_clear_pdma_a: assert property (@(posedge sys_clk) disable iff (rst)
    gnt_vec[2] || !pdma_req |=> cnt_reg[2] == '0)
    else $error("port dma counter not cleared");

  // ------------------------------------------------------------------
  // Checks: registers
  // ------------------------------------------------------------------
  cpu_pri_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == L2BW_ADDR_CPU_ARB
    |=> pri_cpu == $past(reg_wdata[L2BW_CPU_PRI_LSB +: L2BW_PRI_W]))
    else $error("cpu priority not taken");

  ldma_pri_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == L2BW_ADDR_DMA_CNT
    |=> pri_ldma == $past(reg_wdata[L2BW_DMA_PRI_LSB +: L2BW_PRI_W]))
    else $error("internal dma priority not taken");

  mst_a_take_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == L2BW_ADDR_MST_A
    |=> mst_a_reg == $past(reg_wdata))
    else $error("master word a not taken");

  mst_b_take_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == L2BW_ADDR_MST_B
    |=> mst_b_reg == $past(reg_wdata))
    else $error("master word b not taken");

  max_wait_take_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == L2BW_ADDR_MAX_WAIT
    |=> max_wait_reg == $past(reg_wdata[L2BW_CNT_W-1:0]))
    else $error("threshold not taken");

  rd_once_a: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data stood too long");

  rd_status_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == L2BW_ADDR_STATUS
    |=> reg_rdata == {8'h00, $past(cnt_reg[2]), $past(cnt_reg[1]),
                      $past(cnt_reg[0])})
    else $error("status read wrong");

  // ------------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------------
  starve_c: cover property (@(posedge sys_clk) disable iff (rst) |starved);
  tie_c: cover property (@(posedge sys_clk) disable iff (rst)
    cpu_req && dma_req && pri_cpu == pri_dma && !(|starved));
  pdma_c: cover property (@(posedge sys_clk) disable iff (rst) pdma_gnt);
  ldma_starve_c: cover property (@(posedge sys_clk) disable iff (rst)
    starved[1] && ldma_gnt);
  dma_tie_c: cover property (@(posedge sys_clk) disable iff (rst)
    ldma_req && pdma_req && pri_ldma == pri_pdma);
endmodule : l2bw_arbiter

// [bench/l2bw_req_model.sv]
// Requester model for one L2 master facing the arbiter
`timescale 1ns/100ps
module l2bw_req_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control: 0 idle, 1 stream, 2 random
  input wire logic [1:0] mode,
  // Handshake
  input wire logic gnt,
  output logic req
);
  // Random mode holds a request until granted, like a real master
  always_ff @(posedge sys_clk) begin
    if (rst || mode == 2'h0) req <= 1'b0;
    else if (mode == 2'h1) req <= 1'b1;
    else if (!req || gnt) req <= 1'($urandom_range(0, 1));
  end
endmodule : l2bw_req_model

// [bench/tb.sv]
// Self-checking testbench for the L2 bandwidth arbiter
`timescale 1ns/100ps
module tb;
  import l2bw_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [2:0] mid = 3'h0;
  logic [2:0] req;
  logic [2:0] gnt;
  logic [2:0][1:0] mode = 6'h0;
  logic [2:0] c;
  int bad_count = 0;
  int checks = 0;
  int gc, gi, gs;
  // Bit 2 cpu, bit 1 internal dma, bit 0 slave-port dma
  for (genvar k = 0; k < 3; k++) begin : g_req
    l2bw_req_model i_l2bw_req_model (.sys_clk(sys_clk), .rst(rst), .mode(mode[k]),
      .gnt(gnt[k]), .req(req[k]));
  end
  l2bw_arbiter i_l2bw_arbiter (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_req(req[2]), .ldma_req(req[1]), .pdma_req(req[0]), .pdma_master_id(mid),
    .cpu_gnt(gnt[2]), .ldma_gnt(gnt[1]), .pdma_gnt(gnt[0]));
  initial forever #12.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] fld(logic [31:0] w, int lsb, logic [2:0] p);
    fld = w;
    fld[lsb +: 3] = p;
  endfunction : fld
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask : rd
  task automatic run(input int n);
    gc = 0;
    gi = 0;
    gs = 0;
    repeat (n) begin
      @(negedge sys_clk);
      chk({29'h0, gnt & ~req}, 32'h0);
      chk({31'h0, $onehot0(gnt)}, 32'h1);
      chk({31'h0, |gnt}, {31'h0, |req});
      gc += gnt[2];
      gi += gnt[1];
      gs += gnt[0];
    end
  endtask : run
  task automatic go(input logic [5:0] m, input int n, input int ec, ei, es);
    @(posedge sys_clk);
    mode <= m;
    @(posedge sys_clk);
    run(n);
    chk(gc, ec);
    chk(gi, ei);
    chk(gs, es);
    @(posedge sys_clk);
    mode <= 6'h0;
    @(posedge sys_clk);
  endtask : go
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    #200us;
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'hc58e7c0b));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(L2BW_ADDR_CPU_ARB, L2BW_RST_CPU_ARB);
    rd(L2BW_ADDR_DMA_CNT, L2BW_RST_DMA_CNT);
    rd(L2BW_ADDR_MST_A, L2BW_RST_MST);
    rd(L2BW_ADDR_MST_B, L2BW_RST_MST);
    rd(L2BW_ADDR_MAX_WAIT, {24'h0, L2BW_RST_MAX_WAIT});
    wr(32'h0184_1010, 32'hffff_ffff);
    rd(32'h0184_1010, 32'h0);
    go(6'b010100, 8, 0, 8, 0);
    wr(L2BW_ADDR_CPU_ARB, fld(32'h0, L2BW_CPU_PRI_LSB, 3'h2));
    wr(L2BW_ADDR_DMA_CNT, fld(32'h0000_0123, L2BW_DMA_PRI_LSB, 3'h2));
    go(6'b010100, 8, 4, 4, 0);
    wr(L2BW_ADDR_MST_B, fld(L2BW_RST_MST, (5 * L2BW_MST_LSB_STEP) % 32, 3'h0));
    rd(L2BW_ADDR_MST_B, fld(L2BW_RST_MST, (5 * L2BW_MST_LSB_STEP) % 32, 3'h0));
    mid <= 3'h5;
    go(6'b010001, 8, 0, 0, 8);
    wr(L2BW_ADDR_MST_A, fld(L2BW_RST_MST, 2 * L2BW_MST_LSB_STEP, 3'h2));
    wr(L2BW_ADDR_CPU_ARB, fld(32'h0, L2BW_CPU_PRI_LSB, 3'h6));
    mid <= 3'h2;
    go(6'b000101, 8, 0, 4, 4);
    wr(L2BW_ADDR_MAX_WAIT, 32'h0000_0004);
    rd(L2BW_ADDR_MAX_WAIT, 32'h0000_0004);
    wr(L2BW_ADDR_CPU_ARB, fld(32'h0, L2BW_CPU_PRI_LSB, 3'h0));
    wr(L2BW_ADDR_DMA_CNT, fld(32'h0, L2BW_DMA_PRI_LSB, 3'h5));
    go(6'b010100, 15, 12, 3, 0);
    rd(L2BW_ADDR_STATUS, 32'h0);
    repeat (10) begin
      c = 3'($urandom_range(0, 6));
      wr(L2BW_ADDR_CPU_ARB, fld($urandom, L2BW_CPU_PRI_LSB, c));
      c = 3'((c + 1 + $urandom_range(0, 5)) % 8);
      wr(L2BW_ADDR_DMA_CNT, fld($urandom, L2BW_DMA_PRI_LSB, c));
      wr(L2BW_ADDR_MST_A, {8{1'b0, c}});
      wr(L2BW_ADDR_MST_B, {8{1'b0, c}});
      mid <= 3'($urandom);
      mode <= 6'b101010;
      run(20);
    end
    close_out();
  end
endmodule : tb
